// ===== rtl/eom_device.sv
// Eye opening monitor: register file on the link, grid sweep engine,
// opening measurement and lock check.
// Assumes comparator decisions and lock state machine signals on aclk.
`timescale 1ns/1ps
module eom_device
  import eom_pkg::*;
#(
  parameter int REMEASURE_CYC = REMEASURE_CYCLES,
  parameter int DWELL_SHIFT = ACC_SHIFT // Samples per accumulation step, as a power of two
)
(
  input wire logic aclk,
  input wire logic aresetn,
  eom_link_if.dev link,
  input wire logic primary_bit,
  input wire logic offset_bit,
  input wire logic sample_valid,
  input wire logic lock_check_req,
  input wire logic [1:0] lock_range,
  output logic [5:0] phase_offset,
  output logic [5:0] volt_offset,
  output logic [1:0] volt_range,
  output logic monitor_power_on,
  output logic lock_loss
);

  typedef enum logic [1:0] {ST_IDLE, ST_HSW, ST_VSW, ST_EXT} eom_state_e;

  // Opening count to byte, full row saturates
  function automatic logic [7:0] open_byte(input logic [6:0] n);
    open_byte = n[6] ? 8'hFF : {n[5:0], 2'b00};
  endfunction

  // Link synchronisers
  logic clk_s1, clk_s2, clk_d; // Link clock stages
  logic [17:0] bus_s1, bus_s2; // Request bundle stages
  logic rise; // Link clock rising edge
  logic acc, wr, rd, rd_hi, rd_lo; // Decoded accesses
  logic [7:0] a, d; // Synchronised address and data
  logic [7:0] rdata_q; // Read answer

  // Configuration
  logic [1:0] ctrl_range; // Manual range code
  logic ctrl_pd; // Monitor power-down
  logic ovr; // Monitor override
  logic fast; // Fast sweep mode
  logic [7:0] accum; // Accumulation time
  logic rsrc; // Range from lock machine
  logic lockmon; // Lock monitor enable
  logic [7:0] thresh; // Opening thresholds

  // Engine
  eom_state_e st; // Sweep state
  logic start; // Start bit
  logic [5:0] ph, vo; // Current offsets
  logic [18:0] samp; // Samples this dwell
  logic [18:0] target; // Dwell length
  logic dwell_done; // Dwell complete
  logic [15:0] errs; // Error counter
  logic loaded, slot_full, byte_sel, fin; // Readout flags
  logic [7:0] cnt_hi, cnt_lo; // Count registers
  logic [7:0] hopen, vopen; // Latest openings
  logic [6:0] h_cnt, v_cnt, v_eff; // Open point counts
  logic [5:0] first_ph, last_ph, first_eff, last_eff; // Open run bounds
  logic [6:0] mid_sum; // Midpoint sum
  logic seen; // Open phase found
  logic [31:0] tmr; // Remeasure timer
  logic tmr_hit; // Timer expiry
  logic [7:0] thr_h, thr_v; // Threshold bytes

  // Two flops on every link input before use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_d <= 1'b0;
      bus_s1 <= 18'h00000;
      bus_s2 <= 18'h00000;
    end
    else
    begin
      clk_s1 <= link.link_clk;
      clk_s2 <= clk_s1;
      clk_d <= clk_s2;
      bus_s1 <= {link.req, link.we, link.addr, link.wdata};
      bus_s2 <= bus_s1;
    end
  end

  // Access decode at each link rising edge
  assign rise = clk_s2 & ~clk_d;
  assign acc = rise & bus_s2[17];
  assign wr = acc & bus_s2[16];
  assign rd = acc & ~bus_s2[16];
  assign a = bus_s2[15:8];
  assign d = bus_s2[7:0];
  assign rd_hi = rd && (a == REG_CNT_HI);
  assign rd_lo = rd && (a == REG_CNT_LO);

  // Dwell length scales with accumulation time
  assign target = (19'(accum) + 19'h00001) << DWELL_SHIFT;
  assign dwell_done = (samp == target);
  assign tmr_hit = (tmr == 32'(REMEASURE_CYC - 1));
  assign first_eff = seen ? first_ph : ph;
  assign last_eff = (errs == 16'h0000) ? ph : last_ph;
  assign mid_sum = 7'(first_eff) + 7'(last_eff);
  assign v_eff = v_cnt + ((errs == 16'h0000) ? 7'h01 : 7'h00);
  assign thr_h = {thresh[7:4], 4'h0};
  assign thr_v = {thresh[3:0], 4'h0};

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_range <= CTRL_RST[CTRL_RANGE_LSB +: 2];
      ctrl_pd <= CTRL_RST[CTRL_PD_BIT];
      ovr <= 1'b0;
      fast <= 1'b0;
      accum <= ACCUM_RST;
      rsrc <= RSRC_RST[RSRC_BIT];
      lockmon <= 1'b0;
      thresh <= THRESH_RST;
    end
    else if (wr)
    begin
      case (a)
        REG_CTRL:
        begin
          // Range and power-down in one write
          ctrl_range <= d[CTRL_RANGE_LSB +: 2];
          ctrl_pd <= d[CTRL_PD_BIT];
        end
        REG_OVR: ovr <= d[OVR_BIT];
        REG_SWEEP: fast <= d[SWEEP_FAST_BIT];
        REG_ACCUM: accum <= d;
        REG_RSRC: rsrc <= d[RSRC_BIT];
        REG_LOCKMON: lockmon <= d[LOCKMON_BIT];
        REG_THRESH: thresh <= d;
        default: ;
      endcase
    end
  end

  // Remeasure timer runs while idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || st != ST_IDLE || tmr_hit)
      tmr <= 32'h00000000;
    else
      tmr <= tmr + 32'h00000001;
  end

  // Sweep engine, readout and opening measurement
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= ST_IDLE;
      start <= 1'b0;
      ph <= 6'h00;
      vo <= 6'h00;
      samp <= 19'h00000;
      errs <= 16'h0000;
      loaded <= 1'b0;
      slot_full <= 1'b0;
      byte_sel <= 1'b0;
      fin <= 1'b0;
      cnt_hi <= 8'h00;
      cnt_lo <= 8'h00;
      hopen <= 8'h00;
      vopen <= 8'h00;
      h_cnt <= 7'h00;
      v_cnt <= 7'h00;
      first_ph <= 6'h00;
      last_ph <= 6'h00;
      seen <= 1'b0;
      lock_loss <= 1'b0;
    end
    else
    begin
      lock_loss <= 1'b0;
      // Count samples and mismatches until the dwell is complete
      if (st != ST_IDLE && sample_valid && !dwell_done)
      begin
        samp <= samp + 19'h00001;
        if (primary_bit != offset_bit && errs != 16'hFFFF)
          errs <= errs + 16'h0001;
      end
      case (st)
        ST_IDLE:
          // Periodic measurement, only when powered
          if (tmr_hit && (!ctrl_pd || lock_check_req))
          begin
            st <= ST_HSW;
            ph <= 6'h00;
            vo <= VOLT_MID;
            h_cnt <= 7'h00;
            v_cnt <= 7'h00;
            seen <= 1'b0;
            samp <= 19'h00000;
            errs <= 16'h0000;
          end
        ST_HSW:
          // Phase sweep at mid voltage, find open run
          if (dwell_done)
          begin
            if (errs == 16'h0000)
            begin
              h_cnt <= h_cnt + 7'h01;
              seen <= 1'b1;
              first_ph <= first_eff;
              last_ph <= ph;
            end
            if (ph == GRID_MAX)
            begin
              st <= ST_VSW;
              ph <= mid_sum[6:1];
              vo <= 6'h00;
            end
            else
              ph <= ph + 6'h01;
            samp <= 19'h00000;
            errs <= 16'h0000;
          end
        ST_VSW:
          // Voltage sweep at midpoint phase
          if (dwell_done)
          begin
            v_cnt <= v_eff;
            if (vo == GRID_MAX)
            begin
              hopen <= open_byte(h_cnt);
              vopen <= open_byte(v_eff);
              lock_loss <= lockmon && (open_byte(h_cnt) < thr_h || open_byte(v_eff) < thr_v);
              st <= ST_IDLE;
            end
            else
              vo <= vo + 6'h01;
            samp <= 19'h00000;
            errs <= 16'h0000;
          end
        ST_EXT:
        begin
          // Park a finished count until the previous pair is read
          if (dwell_done && !loaded && !slot_full)
          begin
            cnt_hi <= errs[15:8];
            cnt_lo <= errs[7:0];
            loaded <= 1'b1;
            slot_full <= 1'b1;
          end
          if (rd_hi && slot_full && !byte_sel)
          begin
            cnt_hi <= cnt_lo;
            byte_sel <= 1'b1;
            loaded <= 1'b0;
            samp <= 19'h00000;
            errs <= 16'h0000;
            // Phase inner, voltage outer
            if (ph == GRID_MAX && vo == GRID_MAX)
              fin <= 1'b1;
            else if (ph == GRID_MAX)
            begin
              ph <= 6'h00;
              vo <= vo + 6'h01;
            end
            else
              ph <= ph + 6'h01;
          end
          else if ((rd_hi || rd_lo) && byte_sel)
          begin
            byte_sel <= 1'b0;
            slot_full <= 1'b0;
            if (fin)
            begin
              start <= 1'b0;
              st <= ST_IDLE;
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
      // Start write wins over state, offsets, dwell counters and readout flags
      if (wr && a == REG_SWEEP && d[SWEEP_START_BIT])
      begin
        start <= 1'b1;
        st <= ST_EXT;
        ph <= 6'h00;
        vo <= 6'h00;
        samp <= 19'h00000;
        errs <= 16'h0000;
        loaded <= 1'b0;
        slot_full <= 1'b0;
        byte_sel <= 1'b0;
        fin <= 1'b0;
      end
    end
  end

  // Read answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rdata_q <= 8'h00;
    else if (rd)
    begin
      case (a)
        REG_CTRL: rdata_q <= {ctrl_range, ctrl_pd, 5'h00};
        REG_OVR: rdata_q <= {ovr, 7'h00};
        REG_SWEEP: rdata_q <= {fast, 6'h00, start};
        REG_CNT_HI: rdata_q <= cnt_hi;
        REG_CNT_LO: rdata_q <= cnt_lo;
        REG_HOPEN: rdata_q <= hopen;
        REG_VOPEN: rdata_q <= vopen;
        REG_ACCUM: rdata_q <= accum;
        REG_RSRC: rdata_q <= {1'b0, rsrc, 6'h00};
        REG_LOCKMON: rdata_q <= {lockmon, 7'h00};
        REG_THRESH: rdata_q <= thresh;
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign link.rdata = rdata_q;

  // Power and range outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      monitor_power_on <= 1'b0;
      volt_range <= 2'h0;
    end
    else
    begin
      monitor_power_on <= !ctrl_pd || lock_check_req;
      // Code 0..3 selects 100..400 mV
      volt_range <= rsrc ? lock_range : ctrl_range;
    end
  end

  // Offsets come straight from the sweep flops
  assign phase_offset = ph;
  assign volt_offset = vo;

endmodule

// ===== rtl/eom_pkg.sv
// Package for the eye opening monitor and its controller: register map,
// field positions, reset values and timing counts.
// Assumes a 100 MHz aclk shared by both ends.
package eom_pkg;
  // Clock rate
  localparam int CLK_MHZ = 100;
  // Monitor register offsets on the link
  localparam logic [7:0] REG_CTRL = 8'h11;
  localparam logic [7:0] REG_OVR = 8'h22;
  localparam logic [7:0] REG_SWEEP = 8'h24;
  localparam logic [7:0] REG_CNT_HI = 8'h25;
  localparam logic [7:0] REG_CNT_LO = 8'h26;
  localparam logic [7:0] REG_HOPEN = 8'h27;
  localparam logic [7:0] REG_VOPEN = 8'h28;
  localparam logic [7:0] REG_ACCUM = 8'h2A;
  localparam logic [7:0] REG_RSRC = 8'h2C;
  localparam logic [7:0] REG_LOCKMON = 8'h3E;
  localparam logic [7:0] REG_THRESH = 8'h6A;
  // Field positions
  localparam int CTRL_RANGE_LSB = 6;
  localparam int CTRL_PD_BIT = 5;
  localparam int OVR_BIT = 7;
  localparam int SWEEP_FAST_BIT = 7;
  localparam int SWEEP_START_BIT = 0;
  localparam int RSRC_BIT = 6;
  localparam int LOCKMON_BIT = 7;
  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h20;
  localparam logic [7:0] RSRC_RST = 8'h40;
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h44;
  // Grid geometry and dwell scaling
  localparam logic [5:0] GRID_MAX = 6'h3F;
  localparam logic [5:0] VOLT_MID = 6'h20;
  localparam int ACC_SHIFT = 10;
  // Periodic remeasure interval
  localparam int REMEASURE_US = 100;
  localparam int REMEASURE_CYCLES = REMEASURE_US * CLK_MHZ;
  // Link clock half period in aclk cycles
  localparam logic [3:0] LINK_HALF = 4'h8;
  // Controller register offsets on AXI4-Lite
  localparam logic [3:0] CTL_CMD = 4'h0;
  localparam logic [3:0] CTL_STATUS = 4'h4;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_RDATA_LSB = 8;
endpackage

// ===== rtl/eom_link_if.sv
// Link between the system controller and the eye opening monitor.
// Controller makes link_clk and changes its outputs while link_clk is low.
`timescale 1ns/1ps
interface eom_link_if;
  logic link_clk; // Link clock from controller
  logic req; // Access request, held one link period
  logic we; // One for write
  logic [7:0] addr; // Register offset
  logic [7:0] wdata; // Write byte
  logic [7:0] rdata; // Read byte from monitor
  modport dev (input link_clk, input req, input we, input addr, input wdata, output rdata);
  modport ctl (output link_clk, output req, output we, output addr, output wdata, input rdata);
endinterface

// ===== rtl/eom_controller.sv
// System controller end: AXI4-Lite slave with a command and a status
// register, and the link master that generates link_clk by division.
// Assumes software keeps the monitor's access ordering.
`timescale 1ns/1ps
module eom_controller
  import eom_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  eom_link_if.ctl link
);

  typedef enum logic [1:0] {CT_IDLE, CT_RISE, CT_FALL} eom_ctl_e;

  logic [3:0] aw_q; // Held write address
  logic [31:0] w_q; // Held write data
  logic [3:0] ws_q; // Held strobes
  logic aw_got, w_got; // Channel captured flags
  logic launch; // Command accepted
  logic [3:0] div; // Link clock divider
  logic lclk, tick, fall, rise; // Link clock and edges
  eom_ctl_e st; // Link state
  logic busy, pend; // Command in flight
  logic req, we; // Link outputs
  logic [7:0] addr, wdata, last_rd; // Link byte registers
  logic [7:0] rd_s1, rd_s2; // Read data synchroniser
  logic c_we; // Command write flag awaiting launch
  logic [7:0] c_addr, c_wdata; // Command bytes awaiting launch

  // Capture write address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Response after both halves
      if (aw_got && w_got && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q == CTL_CMD && ws_q == 4'hF) ? 2'h0 : 2'h2;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Command write taken only when the link is idle
  assign launch = aw_got && w_got && !s_axi_bvalid && aw_q == CTL_CMD && ws_q == 4'hF && !busy;

  // Register reads
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        CTL_CMD:
        begin
          s_axi_rdata <= {15'h0000, we, wdata, addr};
          s_axi_rresp <= 2'h0;
        end
        CTL_STATUS:
        begin
          s_axi_rdata <= {16'h0000, last_rd, 7'h00, busy};
          s_axi_rresp <= 2'h0;
        end
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Link clock divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div <= 4'h0;
      lclk <= 1'b0;
    end
    else if (tick)
    begin
      div <= 4'h0;
      lclk <= ~lclk;
    end
    else
      div <= div + 4'h1;
  end
  assign tick = (div == LINK_HALF - 4'h1);
  assign fall = tick & lclk;
  assign rise = tick & ~lclk;

  // Read data passes two flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_s1 <= 8'h00;
      rd_s2 <= 8'h00;
    end
    else
    begin
      rd_s1 <= link.rdata;
      rd_s2 <= rd_s1;
    end
  end

  // One access per command: drive at a fall, taken at the rise, read at the next fall
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= CT_IDLE;
      busy <= 1'b0;
      pend <= 1'b0;
      req <= 1'b0;
      we <= 1'b0;
      addr <= 8'h00;
      wdata <= 8'h00;
      last_rd <= 8'h00;
      c_we <= 1'b0;
      c_addr <= 8'h00;
      c_wdata <= 8'h00;
    end
    else
    begin
      if (launch)
      begin
        busy <= 1'b1;
        pend <= 1'b1;
        c_addr <= w_q[7:0];
        c_wdata <= w_q[CMD_WDATA_LSB +: 8];
        c_we <= w_q[CMD_WRITE_BIT];
      end
      case (st)
        CT_IDLE:
          if (pend && fall)
          begin
            req <= 1'b1;
            pend <= 1'b0;
            // Link fields move only at a link clock fall
            addr <= c_addr;
            wdata <= c_wdata;
            we <= c_we;
            st <= CT_RISE;
          end
        CT_RISE:
          if (rise)
            st <= CT_FALL;
        CT_FALL:
          if (fall)
          begin
            req <= 1'b0;
            busy <= 1'b0;
            if (!we)
              last_rd <= rd_s2;
            st <= CT_IDLE;
          end
        default: st <= CT_IDLE;
      endcase
    end
  end

  // Link pins from flops
  assign link.link_clk = lclk;
  assign link.req = req;
  assign link.we = we;
  assign link.addr = addr;
  assign link.wdata = wdata;

endmodule

// ===== verification/eom_link_props.sv
// Checker for the link wire that joins controller and monitor.
// Assumes one aclk domain and the signals of one eom_link_if.
`timescale 1ns/1ps
module eom_link_props
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // Link clock and request stay low while reset is held
  a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> !link_clk && !req)
    else $error("link active during reset");
  a_clk_high_half: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(link_clk) |-> link_clk [*8] ##1 !link_clk)
    else $error("link clock high phase wrong");
  a_clk_low_half: assert property (@(posedge aclk) disable iff (!aresetn) $fell(link_clk) |-> !link_clk [*8])
    else $error("link clock low phase short");
  a_req_at_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(req) |-> !link_clk && $past(link_clk))
    else $error("request not launched at link fall");
  a_req_one_period: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(req) |-> req [*8] ##1 req [*8] ##1 !req)
    else $error("request not held one link period");
  a_frame_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    req && $past(req) |-> $stable(addr) && $stable(we) && $stable(wdata))
    else $error("access fields moved inside request");
  a_addr_change_low: assert property (@(posedge aclk) disable iff (!aresetn) $changed(addr) |-> !link_clk)
    else $error("address moved while link clock high");
  a_rdata_by_read: assert property (@(posedge aclk) disable iff (!aresetn) $changed(rdata) |-> req && !we)
    else $error("read byte moved without a read");
  // Main traffic kinds
  c_read_hi: cover property (@(posedge aclk) req && !we && addr == 8'h25 && $rose(link_clk));
  c_start: cover property (@(posedge aclk) req && we && addr == 8'h24 && wdata[0] && $rose(link_clk));
  c_read_open: cover property (@(posedge aclk) req && !we && addr == 8'h28 && $rose(link_clk));
endmodule

// ===== verification/eye_opening_monitor_tb.sv
// Bench for controller and monitor joined by the link interface.
// Assumes software access over AXI4-Lite, a short remeasure interval and a short dwell step.
`timescale 1ns/1ps
module eye_opening_monitor_tb
  import eom_pkg::*;
;
  logic aclk = 0;
  logic aresetn = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid, lock_loss, monitor_power_on;
  logic [1:0] bresp, rresp, volt_range;
  logic [31:0] rdata;
  logic primary_bit = 0, sample_valid = 1, lock_check_req = 0;
  logic offset_bit;
  logic [1:0] lock_range = 2'h2;
  logic [5:0] phase_offset, volt_offset;
  int n_errors = 0, checks_done = 0, err_mode = 0;
  // Clock of 10 ns
  always #5 aclk = ~aclk;
  // Comparator pair; offset decision follows the offset applied now, no lag
  always @(posedge aclk)
    primary_bit <= ~primary_bit;
  assign offset_bit = primary_bit ^ (err_mode == 3 || (err_mode == 4 && primary_bit)
    || (err_mode == 1 && volt_offset >= 6'h30) || (err_mode == 2 && volt_offset >= 6'h28));
  eom_link_if link ();
  eom_device #(.REMEASURE_CYC(200), .DWELL_SHIFT(4)) i_eom_device (.aclk(aclk), .aresetn(aresetn), .link(link),
    .primary_bit(primary_bit), .offset_bit(offset_bit), .sample_valid(sample_valid),
    .lock_check_req(lock_check_req), .lock_range(lock_range), .phase_offset(phase_offset),
    .volt_offset(volt_offset), .volt_range(volt_range), .monitor_power_on(monitor_power_on),
    .lock_loss(lock_loss));
  eom_controller i_eom_controller (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  eom_link_props i_eom_link_props (.aclk(aclk), .aresetn(aresetn), .link_clk(link.link_clk),
    .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // AXI write, channels released as taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // AXI read
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // One link access through the command register, busy polled
  task automatic lcmd(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    axi_wr(CTL_CMD, {15'h0, w, d, a}, r);
    chk(r, 2'h0, "cmd response");
    s = 1;
    n = 0;
    while (s[0] !== 1'b0 && n < 40)
    begin
      axi_rd(CTL_STATUS, s, r);
      n++;
    end
    chk(s[0], 1'b0, "busy stuck");
    q = s[15:8];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    lcmd(a, d, 1'b1, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
    logic [7:0] q;
    lcmd(a, 8'h00, 1'b0, q);
    chk(q, e, m);
  endtask
  // Wait for a fresh lock loss pulse
  task automatic wait_ll;
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (lock_loss !== 1'b1 && n < 20000);
    chk(n < 20000, 1, "no lock loss");
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rchk(REG_CTRL, 8'h20, "ctrl reset");
    rchk(REG_RSRC, 8'h40, "range source reset");
    rchk(REG_ACCUM, 8'h00, "accum reset");
    rchk(REG_THRESH, 8'h44, "threshold reset");
    rchk(8'h55, 8'h00, "unmapped link read");
    axi_rd(4'h8, d, r);
    chk(r, 2'h2, "bad read address");
    axi_wr(4'h8, 32'h0, r);
    chk(r, 2'h2, "bad write address");
    chk(monitor_power_on, 1'b0, "powered at reset");
    @(posedge aclk);
    lock_check_req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(monitor_power_on, 1'b1, "lock check power");
    lock_check_req <= 1'b0;
    $display("t_reset done");
  endtask
  task automatic t_range;
    wr(REG_CTRL, 8'hC0);
    chk(monitor_power_on, 1'b1, "power bit clear");
    chk(volt_range, 2'h2, "lock machine range");
    wr(REG_RSRC, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(REG_CTRL, {c[1:0], 6'h0});
      chk(volt_range, c[1:0], "range code");
      rchk(REG_CTRL, {c[1:0], 6'h0}, "ctrl readback");
    end
    $display("t_range done");
  endtask
  task automatic t_open;
    err_mode <= 1;
    wr(REG_THRESH, 8'hFD);
    wr(REG_LOCKMON, 8'h80);
    wait_ll;
    wait_ll;
    rchk(REG_HOPEN, 8'hFF, "h opening");
    rchk(REG_VOPEN, 8'hC0, "v opening");
    err_mode <= 2;
    wait_ll;
    wait_ll;
    rchk(REG_VOPEN, 8'hA0, "v remeasured");
    $display("t_open done");
  endtask
  task automatic t_sweep;
    err_mode <= 3;
    wr(REG_LOCKMON, 8'h00);
    wr(REG_OVR, 8'h00);
    wr(REG_ACCUM, 8'h7F);
    wr(REG_SWEEP, 8'h81);
    rchk(REG_SWEEP, 8'h81, "start held");
    chk({volt_offset, phase_offset}, 12'h000, "first point");
    repeat (2300) @(posedge aclk);
    err_mode <= 4;
    rchk(REG_CNT_HI, 8'h08, "point 0 high");
    chk({volt_offset, phase_offset}, 12'h001, "phase steps first");
    rchk(REG_CNT_HI, 8'h00, "point 0 low");
    repeat (2300) @(posedge aclk);
    rchk(REG_CNT_HI, 8'h04, "point 1 high");
    rchk(REG_CNT_LO, 8'h00, "point 1 low");
    chk({volt_offset, phase_offset}, 12'h002, "third point");
    $display("t_sweep done");
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #900000;
    n_errors++;
    $display("BAD %0t watchdog", $time);
    summarize();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_range();
    t_open();
    t_sweep();
    summarize();
  end
endmodule
